// file: hw/fosr_pkg.sv
// Package for the flash status-polling host controller.
// Assumes a parallel NOR flash on an asynchronous bus, polled by read cycles.
package fosr_pkg;
    // ------------------------------------------------------------
    // Clock and bus timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int T_RD_NS = 120;
    localparam int T_WR_NS = 80;
    localparam int T_GAP_NS = 40;
    localparam int RD_CYC = (T_RD_NS * CLK_MHZ + 999) / 1000;
    localparam int WR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_CYC = (T_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    // ------------------------------------------------------------
    // Data bus fields
    // ------------------------------------------------------------
    localparam int DW = 16;
    localparam int AW = 21;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int FAIL_BIT = 5;
    localparam int WINDOW_BIT = 3;
    localparam int SECT_TOGGLE_BIT = 2;
    localparam int CMD_W = 8;
    // ------------------------------------------------------------
    // Command sequence
    // ------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_UNLOCK1 = 21'h00_0555;
    localparam logic [AW-1:0] ADDR_UNLOCK2 = 21'h00_02aa;
    localparam logic [CMD_W-1:0] CMD_UNLOCK1 = 8'haa;
    localparam logic [CMD_W-1:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [CMD_W-1:0] CMD_RESET = 8'hf0;
    localparam logic [DW-1:0] DATA_ZERO = 16'h0000;
    // Result codes
    localparam logic [1:0] RES_OK = 2'h0;
    localparam logic [1:0] RES_FAIL = 2'h1;
    localparam logic [1:0] RES_NOT_TAKEN = 2'h2;
    typedef enum logic [1:0] {FOSR_CYC_NONE, FOSR_CYC_READ, FOSR_CYC_WRITE} fosr_cyc_t;
endpackage

// file: hw/fosr_bus_if.sv
// Interface between the sequencer and the bus cycle engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface fosr_bus_if;
    import fosr_pkg::*;
    fosr_cyc_t kind;
    logic start;
    logic done;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport seq (output kind, output start, output addr, output wdata, input done,
                 input rdata);
    modport eng (input kind, input start, input addr, input wdata, output done,
                 output rdata);
endinterface

// file: hw/fosr_cycle.sv
// Asynchronous flash bus cycle engine: one read or write per start.
// Assumes pins go straight to the flash; read data is synchronised here.
`timescale 1ns/1ns
module fosr_cycle
    import fosr_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    fosr_bus_if.eng bus,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [AW-1:0] addr_pin,
    output logic [DW-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DW-1:0] dq_in
);
    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    logic [DW-1:0] dq_s1;
    logic [DW-1:0] dq_s2;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dq_s1 <= DATA_ZERO;
            dq_s2 <= DATA_ZERO;
        end else begin
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
        end
    end
    // ------------------------------------------------------------
    // Cycle timing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FOSR_IDLE, FOSR_ACT, FOSR_GAP} fosr_cst_t;
    fosr_cst_t st;
    logic [CNT_W-1:0] cnt;
    logic is_rd;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= FOSR_IDLE;
            cnt <= '0;
            is_rd <= 1'b0;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            addr_pin <= '0;
            dq_out <= DATA_ZERO;
            dq_oe <= 1'b0;
            bus.done <= 1'b0;
            bus.rdata <= DATA_ZERO;
        end else begin
            bus.done <= 1'b0;
            case (st)
                FOSR_IDLE: begin
                    if (bus.start && bus.kind != FOSR_CYC_NONE) begin
                        is_rd <= (bus.kind == FOSR_CYC_READ);
                        addr_pin <= bus.addr;
                        ce_n <= 1'b0;
                        // Reads open and close chip select so each counts as one step
                        oe_n <= (bus.kind != FOSR_CYC_READ);
                        we_n <= (bus.kind == FOSR_CYC_READ);
                        dq_out <= bus.wdata;
                        dq_oe <= (bus.kind == FOSR_CYC_WRITE);
                        cnt <= (bus.kind == FOSR_CYC_READ) ? CNT_W'(RD_CYC) : CNT_W'(WR_CYC);
                        st <= FOSR_ACT;
                    end
                end
                FOSR_ACT: begin
                    if (cnt == '0) begin
                        // Two-flop delay is covered by the read time margin
                        if (is_rd) begin
                            bus.rdata <= dq_s2;
                        end
                        ce_n <= 1'b1;
                        oe_n <= 1'b1;
                        we_n <= 1'b1;
                        cnt <= CNT_W'(GAP_CYC);
                        st <= FOSR_GAP;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                FOSR_GAP: begin
                    dq_oe <= 1'b0;
                    if (cnt == '0) begin
                        bus.done <= 1'b1;
                        st <= FOSR_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: st <= FOSR_IDLE;
            endcase
        end
    end
endmodule

// file: hw/fosr_host.sv
// Host controller that issues flash operations and polls their status.
// Assumes the flash command words are supplied by the user; pins go to one flash.
//
// Contract
// - Non-blank program locks device; host must send reset sequence.
// - Host checks window bit before and after each added sector erase.
// - Host reads twice and compares toggle; unchanged means done.
// - Toggling with failure bit set: recheck, then reset if still toggling.
// - Host restarts full status check after pausing polling; here op_abort ends the operation with RES_NOT_TAKEN and there is no resume.
`timescale 1ns/1ns
module fosr_host
    import fosr_pkg::*;
#(
    parameter int MAX_WRITES = 6
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic op_start,
    input wire logic [2:0] op_writes,
    input wire logic [MAX_WRITES*AW-1:0] op_addr,
    input wire logic [MAX_WRITES*CMD_W-1:0] op_cmd,
    input wire logic [DW-1:0] op_data,
    input wire logic op_is_add_sector,
    input wire logic op_abort,
    input wire logic word_mode,
    output logic op_busy,
    output logic op_done,
    output logic [1:0] op_result,
    output logic [DW-1:0] last_status,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic byte_n,
    output logic [AW-1:0] addr_pin,
    output logic [DW-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DW-1:0] dq_in,
    input wire logic ready_busy_output
);
    // ------------------------------------------------------------
    // Ready/busy synchroniser
    // ------------------------------------------------------------
    logic rb_s1;
    logic rb_s2;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rb_s1 <= 1'b1;
            rb_s2 <= 1'b1;
        end else begin
            rb_s1 <= ready_busy_output;
            rb_s2 <= rb_s1;
        end
    end
    // ------------------------------------------------------------
    // Bus engine
    // ------------------------------------------------------------
    fosr_bus_if bus ();
    fosr_cycle u_cycle (
        .clock(clock),
        .nrst(nrst),
        .bus(bus),
        .ce_n(ce_n),
        .oe_n(oe_n),
        .we_n(we_n),
        .addr_pin(addr_pin),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .dq_in(dq_in)
    );
    function automatic logic toggled(input logic [DW-1:0] a, input logic [DW-1:0] b);
        toggled = a[TOGGLE_BIT] ^ b[TOGGLE_BIT];
    endfunction
    // ------------------------------------------------------------
    // Width select
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            byte_n <= 1'b1;
        end else if (!op_busy) begin
            // Changing width mid-operation would corrupt the sequence
            byte_n <= word_mode;
        end
    end
    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        FOSR_S_IDLE, FOSR_S_PRE, FOSR_S_WR, FOSR_S_POST, FOSR_S_RD1, FOSR_S_RD2,
        FOSR_S_RD3, FOSR_S_RST1, FOSR_S_RST2, FOSR_S_RST3, FOSR_S_FIN
    } fosr_st_t;
    fosr_st_t st;
    logic [2:0] widx;
    logic [2:0] nwr;
    logic [DW-1:0] first_rd;
    logic [DW-1:0] prev_rd;
    logic [1:0] res;
    logic add_sec;
    logic wait_done;
    logic [AW-1:0] sel_addr;
    logic [CMD_W-1:0] sel_cmd;
    logic last_wr;
    always_comb begin
        sel_addr = op_addr[widx*AW +: AW];
        sel_cmd = op_cmd[widx*CMD_W +: CMD_W];
        last_wr = (widx == nwr - 3'd1);
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= FOSR_S_IDLE;
            widx <= '0;
            nwr <= '0;
            first_rd <= DATA_ZERO;
            prev_rd <= DATA_ZERO;
            res <= RES_OK;
            add_sec <= 1'b0;
            wait_done <= 1'b0;
            op_busy <= 1'b0;
            op_done <= 1'b0;
            op_result <= RES_OK;
            last_status <= DATA_ZERO;
            bus.start <= 1'b0;
            bus.kind <= FOSR_CYC_NONE;
            bus.addr <= '0;
            bus.wdata <= DATA_ZERO;
        end else begin
            bus.start <= 1'b0;
            op_done <= 1'b0;
            if (bus.done) begin
                wait_done <= 1'b0;
            end
            case (st)
                FOSR_S_IDLE: begin
                    // Ready/busy low means the device rejects new commands
                    if (op_start && rb_s2) begin
                        op_busy <= 1'b1;
                        nwr <= op_writes;
                        add_sec <= op_is_add_sector;
                        widx <= '0;
                        res <= RES_OK;
                        st <= op_is_add_sector ? FOSR_S_PRE : FOSR_S_WR;
                        if (op_is_add_sector) begin
                            // Window bit read before an added sector erase
                            bus.kind <= FOSR_CYC_READ;
                            bus.addr <= op_addr[(op_writes-3'd1)*AW +: AW];
                            bus.start <= 1'b1;
                            wait_done <= 1'b1;
                        end
                    end
                end
                FOSR_S_PRE: begin
                    if (bus.done) begin
                        last_status <= bus.rdata;
                        if (bus.rdata[WINDOW_BIT]) begin
                            // Window closed: the device would ignore the command
                            res <= RES_NOT_TAKEN;
                            st <= FOSR_S_FIN;
                        end else begin
                            st <= FOSR_S_WR;
                        end
                    end
                end
                FOSR_S_WR: begin
                    if (!wait_done && !bus.start) begin
                        // Command words go on the low eight lines; the last write of a program puts op_data on all sixteen
                        bus.kind <= FOSR_CYC_WRITE;
                        bus.addr <= sel_addr;
                        bus.wdata <= last_wr && !add_sec && nwr != 3'(MAX_WRITES)
                            ? op_data : {{(DW-CMD_W){1'b0}}, sel_cmd};
                        bus.start <= 1'b1;
                        wait_done <= 1'b1;
                    end else if (bus.done) begin
                        if (last_wr) begin
                            // Status valid after the final write pulse of the sequence
                            widx <= '0;
                            bus.kind <= FOSR_CYC_READ;
                            bus.start <= 1'b1;
                            wait_done <= 1'b1;
                            st <= add_sec ? FOSR_S_POST : FOSR_S_RD1;
                        end else begin
                            widx <= widx + 3'd1;
                        end
                    end
                end
                FOSR_S_POST: begin
                    if (bus.done) begin
                        last_status <= bus.rdata;
                        // High on the second check: command may not have been taken
                        res <= bus.rdata[WINDOW_BIT] ? RES_NOT_TAKEN : RES_OK;
                        st <= FOSR_S_FIN;
                    end
                end
                FOSR_S_RD1: begin
                    if (bus.done) begin
                        // First of two back-to-back reads
                        first_rd <= bus.rdata;
                        bus.start <= 1'b1;
                        wait_done <= 1'b1;
                        st <= FOSR_S_RD2;
                    end
                end
                FOSR_S_RD2: begin
                    if (bus.done) begin
                        last_status <= bus.rdata;
                        prev_rd <= bus.rdata;
                        if (op_abort) begin
                            // A later resume must start from the first read again
                            res <= RES_NOT_TAKEN;
                            st <= FOSR_S_FIN;
                        end else if (!toggled(first_rd, bus.rdata)) begin
                            // Toggle stopped: operation complete
                            res <= RES_OK;
                            st <= FOSR_S_FIN;
                        end else if (bus.rdata[FAIL_BIT]) begin
                            // Failure bit high: recheck toggle once more
                            bus.start <= 1'b1;
                            wait_done <= 1'b1;
                            st <= FOSR_S_RD3;
                        end else begin
                            // Still toggling: poll again
                            bus.start <= 1'b1;
                            wait_done <= 1'b1;
                            st <= FOSR_S_RD1;
                        end
                    end
                end
                FOSR_S_RD3: begin
                    if (bus.done) begin
                        last_status <= bus.rdata;
                        if (toggled(prev_rd, bus.rdata)) begin
                            // Locked in algorithm: recover with reset command
                            res <= RES_FAIL;
                            st <= FOSR_S_RST1;
                        end else begin
                            res <= RES_OK;
                            st <= FOSR_S_FIN;
                        end
                    end
                end
                FOSR_S_RST1: begin
                    bus.kind <= FOSR_CYC_WRITE;
                    bus.addr <= ADDR_UNLOCK1;
                    bus.wdata <= {{(DW-CMD_W){1'b0}}, CMD_UNLOCK1};
                    bus.start <= 1'b1;
                    st <= FOSR_S_RST2;
                end
                FOSR_S_RST2: begin
                    if (bus.done) begin
                        bus.addr <= ADDR_UNLOCK2;
                        bus.wdata <= {{(DW-CMD_W){1'b0}}, CMD_UNLOCK2};
                        bus.start <= 1'b1;
                        st <= FOSR_S_RST3;
                    end
                end
                FOSR_S_RST3: begin
                    if (bus.done) begin
                        bus.addr <= ADDR_UNLOCK1;
                        bus.wdata <= {{(DW-CMD_W){1'b0}}, CMD_RESET};
                        bus.start <= 1'b1;
                        wait_done <= 1'b1;
                        st <= FOSR_S_FIN;
                    end
                end
                FOSR_S_FIN: begin
                    if (!wait_done) begin
                        op_busy <= 1'b0;
                        op_done <= 1'b1;
                        op_result <= res;
                        st <= FOSR_S_IDLE;
                    end
                end
                default: st <= FOSR_S_IDLE;
            endcase
        end
    end
endmodule

// file: verification/fosr_host_props.sv
// Checker on the host controller ports: strobes, handshake and idle state.
// Assumes one clock domain; bound to every host instance at the foot.
`timescale 1ns/1ns
module fosr_host_props
    import fosr_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic word_mode,
    input wire logic ready_busy_output,
    input wire logic op_busy,
    input wire logic op_done,
    input wire logic [1:0] op_result,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic byte_n,
    input wire logic [AW-1:0] addr_pin,
    input wire logic [DW-1:0] dq_out,
    input wire logic dq_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // ----------
    // Bus cycles
    // ----------
    AST_NO_RD_WR: assert property (oe_n || we_n)
        else $error("read and write strobes low together");
    AST_SELECT: assert property (!oe_n || !we_n |-> !ce_n)
        else $error("strobe without chip select");
    AST_NO_FIGHT: assert property (!oe_n |-> !dq_oe)
        else $error("host drives data during a read");
    AST_WR_HOLD: assert property (!we_n && !$past(we_n) |-> $stable({addr_pin, dq_out}))
        else $error("write address or data moved inside a pulse");
    AST_IDLE: assert property (!op_busy && !op_done |-> &{ce_n, oe_n, we_n, !dq_oe})
        else $error("strobes active while idle");
    // ----------
    // Handshake
    // ----------
    AST_DONE_PULSE: assert property (op_done |=> !op_done)
        else $error("done longer than one cycle");
    AST_DONE_IDLE: assert property (op_done |=> !op_busy)
        else $error("busy after done");
    // Busy flash must never be handed a new operation
    AST_REFUSED: assert property (!ready_busy_output [*3] ##0 !op_busy |=> !op_busy)
        else $error("operation started while flash busy");
    property p_byte_follows;
        !op_busy ##1 !op_busy && $stable(word_mode) |-> byte_n == word_mode;
    endproperty
    AST_BYTE: assert property (p_byte_follows)
        else $error("width select does not follow word mode");
    COV_OK: cover property (op_done && op_result == RES_OK);
    COV_FAIL: cover property (op_done && op_result == RES_FAIL);
    COV_NT: cover property (op_done && op_result == RES_NOT_TAKEN);
endmodule
bind fosr_host fosr_host_props i_fosr_host_props (
    .clock(clock), .nrst(nrst), .word_mode(word_mode), .ready_busy_output(ready_busy_output),
    .op_busy(op_busy), .op_done(op_done), .op_result(op_result), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .byte_n(byte_n), .addr_pin(addr_pin), .dq_out(dq_out), .dq_oe(dq_oe)
);

// file: verification/fosr_flash_model.sv
// Behavioural flash: counts command writes, answers status polls, drives ready/busy.
// Assumes pins settle between rising edges; it samples them on falling edges.
`timescale 1ns/1ns
module fosr_flash_model
    import fosr_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic byte_n,
    input wire logic [DW-1:0] dq_out,
    input wire logic [2:0] arm_writes,
    input wire logic [7:0] busy_reads,
    input wire logic fail_mode,
    input wire logic timer_mode,
    input wire logic window_bit,
    output logic [DW-1:0] dq_in,
    output logic ready_busy_output,
    output int resets_seen
);
    logic busy, tgl, stgl, p_wr, p_rd, erase;
    logic [DW-1:0] wd, mem, st, rv;
    int cnt, reads;
    // Open drain with pull-up: low only while busy
    assign ready_busy_output = !busy;
    always_comb begin
        st = DATA_ZERO;
        st[POLL_BIT] = erase ? 1'b0 : ~wd[POLL_BIT];
        st[TOGGLE_BIT] = tgl;
        st[FAIL_BIT] = fail_mode;
        st[WINDOW_BIT] = erase | (timer_mode & window_bit);
        st[SECT_TOGGLE_BIT] = erase | timer_mode ? stgl : 1'b1;
        rv = busy || timer_mode ? st : mem;
    end
    always_ff @(negedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Power-up lands in read mode
            busy <= 1'b0;
            tgl <= 1'b0;
            stgl <= 1'b0;
            p_wr <= 1'b0;
            p_rd <= 1'b0;
            erase <= 1'b0;
            cnt <= 0;
            reads <= 0;
            resets_seen <= 0;
            dq_in <= DATA_ZERO;
        end else begin
            p_wr <= !ce_n && !we_n;
            p_rd <= !ce_n && !oe_n;
            if (!ce_n && !we_n) begin
                wd <= dq_out;
            end
            if (!ce_n && !oe_n) begin
                // Upper lines float in byte mode
                dq_in <= {byte_n ? rv[15:8] : ~dq_in[15:8], rv[7:0]};
            end else begin
                // A released bus must not look like it kept its value
                dq_in <= ~dq_in;
            end
            if (p_rd && (ce_n || oe_n)) begin
                if (busy || timer_mode) begin
                    tgl <= !tgl;
                    stgl <= !stgl;
                    reads <= reads + 1;
                end
                if (!busy) begin
                    cnt <= 0;
                end else if (!fail_mode && reads + 1 >= int'(busy_reads)) begin
                    busy <= 1'b0;
                    mem <= erase ? 16'hffff : wd;
                end
            end
            if (p_wr && (ce_n || we_n)) begin
                if (!busy && cnt + 1 == int'(arm_writes)) begin
                    busy <= 1'b1;
                    erase <= arm_writes == 3'd6;
                    reads <= 0;
                    cnt <= 0;
                end else if (!busy) begin
                    cnt <= cnt + 1;
                end else if (fail_mode && wd[7:0] == CMD_RESET) begin
                    // Only the reset word frees a lock-up
                    busy <= 1'b0;
                    resets_seen <= resets_seen + 1;
                end
            end
        end
    end
endmodule

// file: verification/fosr_host_tb.sv
// Self-checking bench: host orders on the user side, flash model on the pins.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ns
module fosr_host_tb
    import fosr_pkg::*;
;
    typedef struct packed {
        logic chk;
        logic [1:0] res;
        logic [DW-1:0] st;
    } fosr_exp_t;
    fosr_exp_t exp_q[$];
    fosr_exp_t e;
    logic clock, nrst, op_start, op_is_add_sector, op_abort, word_mode, op_busy, op_done;
    logic ce_n, oe_n, we_n, byte_n, dq_oe, ready_busy_output, fail_mode, timer_mode, window_bit;
    logic [2:0] op_writes, arm_writes;
    logic [1:0] op_result, r;
    logic [7:0] busy_reads;
    logic [AW-1:0] addr_pin;
    logic [6*AW-1:0] op_addr;
    logic [6*CMD_W-1:0] op_cmd;
    logic [DW-1:0] op_data, last_status, dq_out, dq_in, d;
    int errors, checked, resets_seen, i, seed;
    fosr_host #(.MAX_WRITES(6)) i_fosr_host (
        .clock(clock), .nrst(nrst), .op_start(op_start), .op_writes(op_writes),
        .op_addr(op_addr), .op_cmd(op_cmd), .op_data(op_data), .op_abort(op_abort),
        .op_is_add_sector(op_is_add_sector), .word_mode(word_mode), .op_busy(op_busy),
        .op_done(op_done), .op_result(op_result), .last_status(last_status), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .byte_n(byte_n), .addr_pin(addr_pin), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in), .ready_busy_output(ready_busy_output)
    );
    fosr_flash_model i_fosr_flash_model (
        .clock(clock), .rst_n(nrst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .byte_n(byte_n),
        .dq_out(dq_out), .arm_writes(arm_writes), .busy_reads(busy_reads),
        .fail_mode(fail_mode), .timer_mode(timer_mode), .window_bit(window_bit),
        .dq_in(dq_in), .ready_busy_output(ready_busy_output), .resets_seen(resets_seen)
    );
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Called on a falling edge; one start pulse, then wait for idle
    task automatic run_op(input logic [2:0] n, input logic [6*CMD_W-1:0] cmds,
        input logic addsec, input logic [1:0] res, input logic chk, input logic [DW-1:0] st);
        int k;
        op_writes = n;
        op_cmd = cmds;
        op_is_add_sector = addsec;
        exp_q.push_back('{chk, res, st});
        op_start = 1'b1;
        @(negedge clock);
        op_start = 1'b0;
        k = 0;
        while (op_busy !== 1'b0 && k < 20000) begin
            @(negedge clock);
            k++;
        end
        if (k == 20000) errors++;
        repeat (4) @(negedge clock);
    endtask
    always @(negedge clock) begin
        if (op_done === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
            check(16'(op_result), 16'(e.res));
            if (e.chk) begin
                check(last_status, e.st);
            end
        end
    end
    initial begin
        #(8 * 60000);
        errors++;
        report_and_stop();
    end
    initial begin
        seed = $urandom(32'hbdef);
        {op_start, op_is_add_sector, op_abort, fail_mode, timer_mode, window_bit} = 6'h00;
        word_mode = 1'b1;
        op_writes = 3'd0;
        op_cmd = '0;
        op_data = DATA_ZERO;
        arm_writes = 3'd4;
        busy_reads = 8'd1;
        nrst = 1'b0;
        for (i = 0; i < 6; i++) begin
            op_addr[i*AW +: AW] = i % 3 == 1 ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
        end
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        // Programs: busy span from a single poll to a dozen
        for (i = 0; i < 5; i++) begin
            d = 16'($urandom);
            op_data = d;
            busy_reads = i == 0 ? 8'd1 : 8'($urandom_range(12, 2));
            run_op(3'd4, 48'h0000_00a0_55aa, 1'b0, RES_OK, 1'b1, d);
            word_mode = 1'($urandom);
            repeat (3) @(negedge clock);
            check({15'h0000, byte_n}, {15'h0000, word_mode});
            word_mode = 1'b1;
            repeat (2) @(negedge clock);
        end
        arm_writes = 3'd6;
        busy_reads = 8'($urandom_range(9, 3));
        run_op(3'd6, 48'h1055_aa80_55aa, 1'b0, RES_OK, 1'b1, 16'hffff);
        arm_writes = 3'd4;
        fail_mode = 1'b1;
        run_op(3'd4, 48'h0000_00a0_55aa, 1'b0, RES_FAIL, 1'b0, DATA_ZERO);
        check(16'(resets_seen), 16'h0001);
        fail_mode = 1'b0;
        arm_writes = 3'd0;
        timer_mode = 1'b1;
        for (i = 0; i < 2; i++) begin
            window_bit = i[0];
            r = i == 1 ? RES_NOT_TAKEN : RES_OK;
            run_op(3'd1, 48'h0000_0000_0030, 1'b1, r, 1'b0, DATA_ZERO);
        end
        timer_mode = 1'b0;
        // Abort leaves the flash busy, so the next start must be refused
        arm_writes = 3'd4;
        busy_reads = 8'hff;
        op_abort = 1'b1;
        run_op(3'd4, 48'h0000_00a0_55aa, 1'b0, RES_NOT_TAKEN, 1'b0, DATA_ZERO);
        op_abort = 1'b0;
        op_start = 1'b1;
        @(negedge clock);
        op_start = 1'b0;
        repeat (4) @(negedge clock);
        check({15'h0000, op_busy}, 16'h0000);
        nrst = 1'b0;
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        busy_reads = 8'd2;
        run_op(3'd4, 48'h0000_00a0_55aa, 1'b0, RES_OK, 1'b1, op_data);
        check(16'(addr_pin), 16'(ADDR_UNLOCK1));
        check(16'(exp_q.size()), 16'h0000);
        report_and_stop();
    end
endmodule
